// >>> pkg/viu_pkg.sv
// Purpose: constants and types for the vectored interrupt unit
// Assumes: one clock, asynchronous active low reset
// Notes: lower priority value means more urgent
// Summary of operation
// - 32 request inputs, each fast or vectored
// - class and priority inputs changeable any time
// - fast class outranks every vectored request
// - fast output is OR of fast requests
// - status word shows requesting fast sources
// - non-fast inputs are vectored with priority
// - equal priority ties go to lowest channel
// - normal output is OR of vectored requests
// - vector address of selected request is output
// - 46 bank pins give rise/fall/both edge requests
// - bank edges merged with external line three
package viu_pkg;
   //--------------------------------------------------
   // sizes
   //--------------------------------------------------
   localparam int VIU_NUM_CHAN = 32;
   localparam int VIU_CHAN_W = 5;
   localparam int VIU_PRIO_W = 4;
   localparam int VIU_ADDR_W = 32;
   localparam int VIU_BANK0_PINS = 32;
   localparam int VIU_BANK2_PINS = 14;
   localparam int VIU_EXT3_CHAN = 17;
   //--------------------------------------------------
   // reset values
   //--------------------------------------------------
   localparam logic [VIU_ADDR_W-1:0] VIU_DEF_VECTOR = 32'h0000_0000;
   localparam logic [VIU_CHAN_W-1:0] VIU_CHAN_RST = 5'h00;
   localparam logic [VIU_NUM_CHAN-1:0] VIU_REQ_RST = 32'h0000_0000;
   localparam logic [VIU_PRIO_W-1:0] VIU_PRIO_WORST = 4'hF;

   // everything handed to the processor core
   typedef struct packed {
      logic fast_irq;
      logic normal_irq;
      logic normal_valid;
      logic [VIU_CHAN_W-1:0] normal_chan;
      logic [VIU_NUM_CHAN-1:0] fast_status;
      logic [VIU_ADDR_W-1:0] vector_addr;
   } viu_core_type;
endpackage : viu_pkg

// >>> verilog/vectored_irq_unit.sv
// Purpose: vectored interrupt unit driving the core's two inputs
// Assumes: request lines are level and synchronous to clk
// Notes: configuration arrives on plain inputs, no register bus
`timescale 1ns/100ps
module vectored_irq_unit
   import viu_pkg::*;
#(
   parameter int NUM_CHAN = VIU_NUM_CHAN,
   parameter int PRIO_W = VIU_PRIO_W,
   parameter int BANK0_PINS = VIU_BANK0_PINS,
   parameter int BANK2_PINS = VIU_BANK2_PINS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [NUM_CHAN-1:0] irq_req,
   input wire logic ext_interrupt_three,
   input wire logic [NUM_CHAN-1:0] fast_sel,
   input wire logic [NUM_CHAN*PRIO_W-1:0] prio_level,
   input wire logic [NUM_CHAN*VIU_ADDR_W-1:0] vector_table,
   input wire logic [BANK0_PINS-1:0] gpio_bank_zero,
   input wire logic [BANK2_PINS-1:0] gpio_bank_two,
   input wire logic [BANK0_PINS+BANK2_PINS-1:0] edge_rise_en,
   input wire logic [BANK0_PINS+BANK2_PINS-1:0] edge_fall_en,
   input wire logic [BANK0_PINS+BANK2_PINS-1:0] edge_flag_clr,
   output viu_core_type core_out,
   output logic [BANK0_PINS+BANK2_PINS-1:0] edge_flag
);
   localparam int NPINS = BANK0_PINS + BANK2_PINS;

   //--------------------------------------------------
   // selection function
   //--------------------------------------------------
   // strict compare keeps the lowest channel on a tie
   function automatic logic [VIU_CHAN_W:0] viu_pick(
      input logic [NUM_CHAN-1:0] act,
      input logic [NUM_CHAN*PRIO_W-1:0] pr);
      logic found;
      logic [VIU_CHAN_W-1:0] idx;
      logic [PRIO_W-1:0] best;
      found = 1'b0;
      idx = VIU_CHAN_RST;
      best = VIU_PRIO_WORST;
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (act[i] && (!found || pr[i*PRIO_W +: PRIO_W] < best)) begin
            found = 1'b1;
            idx = VIU_CHAN_W'(i);
            best = pr[i*PRIO_W +: PRIO_W];
         end
      end
      return {found, idx};
   endfunction : viu_pick

   //--------------------------------------------------
   // bank pin edge detection
   //--------------------------------------------------
   logic [NPINS-1:0] pin_now;
   logic [NPINS-1:0] pin_prev_r;
   logic [NPINS-1:0] edge_hit;
   logic [NPINS-1:0] flag_r;
   logic [NPINS-1:0] flag_nxt;

   // edges seen whatever the pin's selected function
   assign pin_now = {gpio_bank_two, gpio_bank_zero};
   assign edge_hit = (pin_now & ~pin_prev_r & edge_rise_en)
                   | (~pin_now & pin_prev_r & edge_fall_en);
   // set wins so an edge in the clear cycle is kept
   assign flag_nxt = (flag_r & ~edge_flag_clr) | edge_hit;
   assign edge_flag = flag_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_prev_r <= '0;
         flag_r <= '0;
      end else begin
         pin_prev_r <= pin_now;
         flag_r <= flag_nxt;
      end
   end

   //--------------------------------------------------
   // request classing
   //--------------------------------------------------
   logic [NUM_CHAN-1:0] eff_req;
   logic [NUM_CHAN-1:0] fast_req;
   logic [NUM_CHAN-1:0] norm_req;
   logic [VIU_CHAN_W:0] pick;
   logic [VIU_ADDR_W-1:0] pick_addr;

   // one shared channel for bank edges and external line three
   always_comb begin
      eff_req = irq_req;
      eff_req[VIU_EXT3_CHAN] = irq_req[VIU_EXT3_CHAN]
                             | ext_interrupt_three | (|flag_r);
   end
   // class inputs are read live, so software may move them any time
   assign fast_req = eff_req & fast_sel;
   assign norm_req = eff_req & ~fast_sel;
   assign pick = viu_pick(norm_req, prio_level);
   assign pick_addr =
      vector_table[pick[VIU_CHAN_W-1:0]*VIU_ADDR_W +: VIU_ADDR_W];

   //--------------------------------------------------
   // core outputs
   //--------------------------------------------------
   viu_core_type out_r;
   viu_core_type out_nxt;

   // one register stage; costs a cycle but gives clean outputs
   always_comb begin
      out_nxt.fast_irq = |fast_req;
      out_nxt.normal_irq = |norm_req;
      out_nxt.normal_valid = pick[VIU_CHAN_W];
      out_nxt.normal_chan = pick[VIU_CHAN_W-1:0];
      out_nxt.fast_status = fast_req;
      out_nxt.vector_addr = pick[VIU_CHAN_W] ? pick_addr
                                             : VIU_DEF_VECTOR;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_r <= '0;
      end else begin
         out_r <= out_nxt;
      end
   end
   // fast line is a separate core input, never masked by vectored
   assign core_out = out_r;

   //--------------------------------------------------
   // checks
   //--------------------------------------------------
   property p_fast_or;
      @(posedge clk) disable iff (!arst_n)
      out_r.fast_irq == $past(|(eff_req & fast_sel));
   endproperty
   a_fast_or: assert property (p_fast_or)
      else $error("fast output not OR of fast requests");

   property p_norm_or;
      @(posedge clk) disable iff (!arst_n)
      out_r.normal_irq == $past(|(eff_req & ~fast_sel));
   endproperty
   a_norm_or: assert property (p_norm_or)
      else $error("normal output not OR of vectored requests");

   property p_status;
      @(posedge clk) disable iff (!arst_n)
      out_r.fast_status == ($past(eff_req) & $past(fast_sel));
   endproperty
   a_status: assert property (p_status)
      else $error("fast status word wrong");

   property p_sel_not_fast;
      @(posedge clk) disable iff (!arst_n)
      out_r.normal_valid |->
         !$past(fast_sel[pick[VIU_CHAN_W-1:0]]) ##0
         $past(norm_req[pick[VIU_CHAN_W-1:0]]);
   endproperty
   a_sel_not_fast: assert property (p_sel_not_fast)
      else $error("selected vectored request is fast or idle");

   // rank worked out apart from viu_pick, so a broken picker shows up
   logic [NUM_CHAN-1:0] outranks;
   logic [PRIO_W-1:0] pick_prio;

   assign pick_prio = prio_level[pick[VIU_CHAN_W-1:0]*PRIO_W +: PRIO_W];

   // a channel outranks the pick if more urgent, or as urgent and lower
   always_comb begin
      outranks = '0;
      for (int i = 0; i < NUM_CHAN; i++) begin
         outranks[i] = norm_req[i]
            && (prio_level[i*PRIO_W +: PRIO_W] < pick_prio
                || (prio_level[i*PRIO_W +: PRIO_W] == pick_prio
                    && i < int'(pick[VIU_CHAN_W-1:0])));
      end
   end

   property p_rank;
      @(posedge clk) disable iff (!arst_n)
      (norm_req != '0) |-> pick[VIU_CHAN_W] && outranks == '0;
   endproperty
   a_rank: assert property (p_rank)
      else $error("a more urgent vectored request was passed over");

   property p_fast_excl;
      @(posedge clk) disable iff (!arst_n)
      out_r.normal_valid |-> !out_r.fast_status[out_r.normal_chan];
   endproperty
   a_fast_excl: assert property (p_fast_excl)
      else $error("fast source offered as vectored");

   property p_tie_low;
      @(posedge clk) disable iff (!arst_n)
      (pick[VIU_CHAN_W] && pick[VIU_CHAN_W-1:0] != VIU_CHAN_RST)
      |-> !(norm_req[0] && prio_level[PRIO_W-1:0]
            <= prio_level[pick[VIU_CHAN_W-1:0]*PRIO_W +: PRIO_W]);
   endproperty
   a_tie_low: assert property (p_tie_low)
      else $error("channel zero not chosen on equal priority");

   property p_vector;
      @(posedge clk) disable iff (!arst_n)
      out_r.normal_valid |-> out_r.vector_addr == $past(pick_addr);
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector address does not match selection");

   property p_drop;
      @(posedge clk) disable iff (!arst_n)
      (norm_req == '0) |=> !out_r.normal_irq && !out_r.normal_valid;
   endproperty
   a_drop: assert property (p_drop)
      else $error("normal output held after requests cleared");

   // any pin, and the set must win over a clear held in that cycle
   property p_edge_flag;
      @(posedge clk) disable iff (!arst_n)
      (edge_hit != '0) |=>
         ((flag_r & $past(edge_hit)) == $past(edge_hit))
         ##0 eff_req[VIU_EXT3_CHAN];
   endproperty
   a_edge_flag: assert property (p_edge_flag)
      else $error("pin edge not flagged");

   property p_flag_clear;
      @(posedge clk) disable iff (!arst_n)
      (edge_hit == '0 && edge_flag_clr == '1) |=> flag_r == '0;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("edge flags kept through a full clear");

   property p_merge;
      @(posedge clk) disable iff (!arst_n)
      ext_interrupt_three |-> eff_req[VIU_EXT3_CHAN];
   endproperty
   a_merge: assert property (p_merge)
      else $error("external line three not merged");
endmodule : vectored_irq_unit

// >>> bench/viu_periph_model.sv
// Purpose: peripheral side, one held request line each
// Assumes: set and clear strobes come from the bench
// Notes: a level stays until its source clears it
`timescale 1ns/100ps
module viu_periph_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [31:0] set_req,
   input wire logic [31:0] clr_req,
   output logic [31:0] irq_req
);
   // merged flags per peripheral, clear wins so tests can drain
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) irq_req <= 32'h0000_0000;
      else irq_req <= (irq_req | set_req) & ~clr_req;
   end
endmodule : viu_periph_model

// >>> bench/vectored_irq_unit_tb.sv
// Purpose: random and corner checks of the vectored interrupt unit
// Assumes: core_out follows the inputs one edge later
// Notes: bank pins stay low before the edge tests; pin 33 is left high after them
`timescale 1ns/100ps
module vectored_irq_unit_tb;
   import viu_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ext3 = 1'b0;
   logic [31:0] set_r = '0, clr_r = '0, fsel = '0, req, rng = 32'hA4C9;
   logic [127:0] prio = '0;
   logic [1023:0] vtab = '0;
   logic [31:0] bank0 = '0;
   logic [13:0] bank2 = '0;
   logic [45:0] rise = '0, fall = '0, fclr = '1, eflag;
   viu_core_type cout, exp = '0;
   int failures = 0, n_tests = 0, cyc = 0;
   always #2 clk = ~clk;
   viu_periph_model u_per (.clk(clk), .arst_n(arst_n), .set_req(set_r),
      .clr_req(clr_r), .irq_req(req));
   vectored_irq_unit u_dut (.clk(clk), .arst_n(arst_n), .irq_req(req),
      .ext_interrupt_three(ext3), .fast_sel(fsel), .prio_level(prio),
      .vector_table(vtab), .gpio_bank_zero(bank0), .gpio_bank_two(bank2),
      .edge_rise_en(rise), .edge_fall_en(fall), .edge_flag_clr(fclr),
      .core_out(cout), .edge_flag(eflag));
   //--------------------------------------------------
   // helpers
   //--------------------------------------------------
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   // smallest priority wins, scan upward so ties keep lowest channel
   function automatic viu_core_type model(logic [31:0] r, logic e3);
      viu_core_type m;
      logic [31:0] v;
      m = '0;
      r[17] = r[17] | e3;
      v = r & ~fsel;
      m.fast_irq = |(r & fsel);
      m.fast_status = r & fsel;
      for (int i = 0; i < 32; i++) begin
         if (v[i] && (!m.normal_valid ||
             prio[4*i +: 4] < prio[4*m.normal_chan +: 4])) begin
            m.normal_valid = 1'b1;
            m.normal_chan = 5'(i);
         end
      end
      m.normal_irq = m.normal_valid;
      if (m.normal_valid) m.vector_addr = vtab[32*m.normal_chan +: 32];
      return m;
   endfunction : model
   task automatic chk(string nm, logic [79:0] seen, logic [79:0] want);
      n_tests++;
      if (seen !== want) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, want, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   task automatic tick();
      @(posedge clk);
      #1;
      chk("core_out", 80'(cout), 80'(exp));
   endtask : tick
   // expectation taken from the inputs as they stand before the edge
   task automatic run(int n);
      repeat (n) begin
         exp = model(req, ext3);
         tick();
      end
   endtask : run
   // one pin edge, its flag, then the merged channel and the clear
   // hold_clr keeps the clear up through the edge: the set must win
   task automatic edge_try(int p, logic [1:0] mode, logic hold_clr);
      fclr = {46{hold_clr}};
      rise[p] = mode[0];
      fall[p] = mode[1];
      {bank2, bank0} = {bank2, bank0} ^ (46'h1 << p);
      tick();
      chk("edge_flag", 80'(eflag), 80'(46'h1 << p));
      fclr = '1;
      exp = model(32'h0002_0000, 1'b0);
      tick();
      chk("edge_flag", 80'(eflag), 80'h0);
      exp = model(32'h0, 1'b0);
      tick();
      rise = '0;
      fall = '0;
   endtask : edge_try
   // hang guard, sized well above the planned run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      for (int i = 0; i < 32; i++) vtab[32*i +: 32] = xs();
      repeat (12) @(posedge clk);
      #1 arst_n = 1'b1;
      // classes and priorities reshuffled live, narrow range forces ties
      for (int k = 0; k < 400; k++) begin
         tick();
         set_r = xs() & xs() & xs();
         clr_r = xs() & xs();
         ext3 = xs() < 32'h2000_0000;
         if (k % 16 == 0) fsel = xs() & xs();
         for (int i = 0; i < 4; i++) prio[32*i +: 32] = xs() & 32'h3333_3333;
         exp = model(req, ext3);
      end
      $display("test random done");
      set_r = '1;
      clr_r = '0;
      fsel = '0;
      prio = {32{4'h5}};
      run(3);
      prio = {4'h0, {31{4'hF}}};
      run(2);
      fsel = '1;
      run(2);
      $display("test corners done");
      set_r = '0;
      clr_r = '1;
      ext3 = 1'b0;
      fsel = '0;
      run(3);
      edge_try(40, 2'b01, 1'b0);
      bank0[2] = 1'b1;
      run(2);
      edge_try(2, 2'b10, 1'b0);
      edge_try(40, 2'b11, 1'b0);
      edge_try(33, 2'b01, 1'b1);
      $display("test edges done");
      // reset in mid-run must drop every output at once
      set_r = '1;
      clr_r = '0;
      run(2);
      arst_n = 1'b0;
      exp = '0;
      tick();
      chk("edge_flag", 80'(eflag), 80'h0);
      set_r = '0;
      arst_n = 1'b1;
      run(2);
      chk("edge_flag", 80'(eflag), 80'h0);
      $display("test reset done");
      give_verdict();
   end
endmodule : vectored_irq_unit_tb
